// File: ptcs_device.sv
// sequencer end: chains point tables, register setpoints, temporary stop
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module ptcs_device
  import ptcs_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // link to the master
  ptcs_link_if.dev link,
  // manual mode activity
  input wire logic i_homing_active,
  input wire logic i_jog_active,
  // profile generator feedback
  input wire logic i_seg_done,
  input wire logic signed [31:0] i_cur_pos,
  // profile generator command
  output logic o_cmd_valid,
  output logic signed [31:0] o_cmd_target,
  output logic [15:0] o_cmd_speed,
  output logic [15:0] o_cmd_acc,
  output logic [15:0] o_cmd_dec,
  output logic o_cmd_last,
  output logic o_hold,
  output logic signed [31:0] o_remaining
);
  typedef enum logic [1:0] {PTCS_IDLE, PTCS_LOAD, PTCS_RUN, PTCS_HOLD} ptcs_state_t;

  ptcs_state_t state_reg, state_next;
  ptcs_entry_t entry;
  logic fwd_prev_reg, rev_prev_reg, stop_prev_reg;
  logic fwd_edge, rev_edge, stop_edge;
  logic [15:0] pos_lo_reg, pos_hi_reg, speed_word_reg;
  logic [7:0] idx_reg;
  logic signed [31:0] acc_pos_reg, base_reg;
  logic [1:0] prev_aux_reg;
  logic first_reg, inc_sys_reg, rev_reg;
  logic [15:0] acc_reg, dec_reg;
  logic reg_mode, inc_sys, table_start, reg_start, start_ok, stop_ok;
  logic signed [31:0] reg_pos, seg_sum, seg_target;

  ptcs_point_table ptcs_point_table_i (
    .i_ref_clk(i_ref_clk),
    .i_we(link.pt_we),
    .i_waddr(link.pt_addr),
    .i_wdata(link.pt_data),
    .i_raddr(idx_reg),
    .o_rdata(entry)
  );

  // ----------------------------------------------------------------------
  // remote input edges
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fwd_prev_reg <= 1'b0;
      rev_prev_reg <= 1'b0;
      stop_prev_reg <= 1'b0;
    end else begin
      fwd_prev_reg <= link.fwd_start;
      rev_prev_reg <= link.rev_start;
      stop_prev_reg <= link.temporary_stop_request;
    end
  end

  assign fwd_edge = link.fwd_start && !fwd_prev_reg;
  assign rev_edge = link.rev_start && !rev_prev_reg;
  assign stop_edge = link.temporary_stop_request && !stop_prev_reg;

  // ----------------------------------------------------------------------
  // remote register words
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pos_lo_reg <= PTCS_WORD_RST;
      pos_hi_reg <= PTCS_WORD_RST;
      speed_word_reg <= PTCS_WORD_RST;
    end else if (link.rw_we) begin
      case (link.rw_addr)
        PTCS_OFS_POS_LO: pos_lo_reg <= link.rw_data;
        PTCS_OFS_POS_HI: pos_hi_reg <= link.rw_data;
        PTCS_OFS_SPEED: speed_word_reg <= link.rw_data;
        default: ;
      endcase
    end
  end

  assign reg_pos = {pos_hi_reg, pos_lo_reg};
  assign inc_sys = (link.command_system_param != PTCS_CMD_SYS_ABS);
  assign reg_mode = link.setpoint_source_select
                    && (link.setpoint_source_param == PTCS_SRC_PARAM_REG)
                    && (link.station_count == PTCS_STATIONS_REG);
  // reverse start is only meaningful in the incremental system
  assign start_ok = link.auto_manual_select && (state_reg == PTCS_IDLE);
  assign table_start = start_ok && !reg_mode && (fwd_edge || (rev_edge && inc_sys));
  assign reg_start = start_ok && reg_mode && fwd_edge;
  assign stop_ok = stop_edge && !i_homing_active && !i_jog_active;

  // ----------------------------------------------------------------------
  // segment target of the entry being loaded
  // ----------------------------------------------------------------------
  always_comb begin
    seg_sum = acc_pos_reg + entry.pos;
    if (inc_sys_reg) begin
      seg_target = rev_reg ? (base_reg - seg_sum) : (base_reg + seg_sum);
    end else if (first_reg || (prev_aux_reg != PTCS_AUX_NEXT_INC)) begin
      seg_target = entry.pos;
    end else begin
      seg_target = seg_sum;
    end
  end

  // ----------------------------------------------------------------------
  // sequence state
  // ----------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PTCS_IDLE: begin
        if (table_start) begin
          state_next = PTCS_LOAD;
        end else if (reg_start) begin
          state_next = PTCS_RUN;
        end
      end
      PTCS_LOAD: state_next = PTCS_RUN;
      PTCS_RUN: begin
        if (stop_ok) begin
          state_next = PTCS_HOLD;
        end else if (i_seg_done) begin
          state_next = o_cmd_last ? PTCS_IDLE : PTCS_LOAD;
        end
      end
      PTCS_HOLD: begin
        if (!link.auto_manual_select) begin
          state_next = PTCS_IDLE;
        end else if (stop_ok) begin
          state_next = PTCS_RUN;
        end
      end
      default: state_next = PTCS_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= PTCS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // chain bookkeeping
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      idx_reg <= 8'h00;
      acc_pos_reg <= PTCS_POS_RST;
      base_reg <= PTCS_POS_RST;
      prev_aux_reg <= PTCS_AUX_END;
      first_reg <= 1'b0;
      inc_sys_reg <= 1'b0;
      rev_reg <= 1'b0;
      acc_reg <= PTCS_WORD_RST;
      dec_reg <= PTCS_WORD_RST;
    end else if (table_start) begin
      idx_reg <= link.pt_select;
      acc_pos_reg <= PTCS_POS_RST;
      base_reg <= i_cur_pos;
      first_reg <= 1'b1;
      inc_sys_reg <= inc_sys;
      rev_reg <= !fwd_edge;
    end else if (state_reg == PTCS_LOAD) begin
      acc_pos_reg <= inc_sys_reg ? seg_sum : seg_target;
      prev_aux_reg <= entry.aux;
      first_reg <= 1'b0;
      if (first_reg) begin
        acc_reg <= entry.acc;
        dec_reg <= entry.dec;
      end
    end else if ((state_reg == PTCS_RUN) && i_seg_done && !stop_ok && !o_cmd_last) begin
      idx_reg <= idx_reg + 8'h01;
    end
  end

  // ----------------------------------------------------------------------
  // command to the profile generator
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_valid <= 1'b0;
      o_cmd_target <= PTCS_POS_RST;
      o_cmd_speed <= PTCS_WORD_RST;
      o_cmd_acc <= PTCS_WORD_RST;
      o_cmd_dec <= PTCS_WORD_RST;
      o_cmd_last <= 1'b0;
    end else begin
      o_cmd_valid <= 1'b0;
      if (reg_start) begin
        o_cmd_valid <= 1'b1;
        // select bit taken only at this edge; incremental system ignores it
        o_cmd_target <= (inc_sys || link.abs_inc_select) ? (i_cur_pos + reg_pos)
                                                          : reg_pos;
        o_cmd_speed <= speed_word_reg;
        o_cmd_last <= 1'b1;
      end else if (state_reg == PTCS_LOAD) begin
        o_cmd_valid <= 1'b1;
        o_cmd_target <= seg_target;
        o_cmd_speed <= entry.speed;
        o_cmd_acc <= first_reg ? entry.acc : acc_reg;
        o_cmd_dec <= first_reg ? entry.dec : dec_reg;
        o_cmd_last <= inc_sys_reg ? (entry.aux == PTCS_AUX_END)
                                  : ptcs_is_end(entry.aux);
      end else if ((state_reg == PTCS_HOLD) && link.auto_manual_select && stop_ok) begin
        o_cmd_valid <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // temporary stop and remaining distance
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_hold <= 1'b0;
      o_remaining <= PTCS_POS_RST;
    end else if ((state_reg == PTCS_RUN) && stop_ok) begin
      o_hold <= 1'b1;
      o_remaining <= o_cmd_target - i_cur_pos;
    end else if (state_reg == PTCS_HOLD) begin
      if (!link.auto_manual_select) begin
        o_hold <= 1'b0;
        o_remaining <= PTCS_POS_RST;
      end else if (stop_ok) begin
        o_hold <= 1'b0;
      end
    end
  end

  assign link.busy = (state_reg != PTCS_IDLE);
  assign link.held = (state_reg == PTCS_HOLD);
endmodule : ptcs_device
`default_nettype wire

// File: ptcs_host.sv
// master end: drives remote bits, writes setpoint words, loads point table
`timescale 1ns/1ps
`default_nettype none
module ptcs_host
  import ptcs_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // link to the sequencer
  ptcs_link_if.host link,
  // remote bit levels
  input wire logic i_fwd_start,
  input wire logic i_rev_start,
  input wire logic i_auto,
  input wire logic i_stop_request,
  input wire logic i_reg_setpoints,
  input wire logic i_abs_inc,
  input wire logic [7:0] i_pt_select,
  input wire logic i_inc_system,
  // setpoint load request
  input wire logic i_sp_valid,
  input wire logic signed [31:0] i_sp_pos,
  input wire logic [15:0] i_sp_speed,
  output logic o_sp_ready,
  // point table load
  input wire logic i_pt_we,
  input wire logic [7:0] i_pt_addr,
  input wire ptcs_entry_t i_pt_data,
  input wire logic i_pt_last,
  // status
  output logic o_busy,
  output logic o_held
);
  typedef enum logic [1:0] {PTCS_H_IDLE, PTCS_H_LO, PTCS_H_HI, PTCS_H_SPD} ptcs_hstate_t;

  ptcs_hstate_t hstate_reg;
  logic signed [31:0] pos_reg;
  logic [15:0] speed_reg;
  logic signed [31:0] clamped;
  ptcs_entry_t fixed;

  // ----------------------------------------------------------------------
  // remote bits and configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.fwd_start <= 1'b0;
      link.rev_start <= 1'b0;
      link.auto_manual_select <= 1'b0;
      link.temporary_stop_request <= 1'b0;
      link.setpoint_source_select <= 1'b0;
      link.abs_inc_select <= 1'b0;
      link.pt_select <= 8'h00;
      link.command_system_param <= PTCS_CMD_SYS_ABS;
      link.setpoint_source_param <= PTCS_SRC_PARAM_TABLE;
    end else begin
      link.fwd_start <= i_fwd_start;
      link.rev_start <= i_rev_start;
      link.auto_manual_select <= i_auto || i_reg_setpoints;
      link.temporary_stop_request <= i_stop_request;
      link.setpoint_source_select <= i_reg_setpoints;
      link.abs_inc_select <= i_abs_inc;
      link.pt_select <= i_pt_select;
      link.command_system_param <= i_inc_system ? PTCS_CMD_SYS_INC : PTCS_CMD_SYS_ABS;
      link.setpoint_source_param <= i_reg_setpoints ? PTCS_SRC_PARAM_REG
                                                    : PTCS_SRC_PARAM_TABLE;
    end
  end

  assign link.station_count = PTCS_STATIONS_REG;

  // ----------------------------------------------------------------------
  // setpoint words: low, high, speed on three cycles
  // ----------------------------------------------------------------------
  always_comb begin
    clamped = i_sp_pos;
    if (!i_inc_system && (i_sp_pos < PTCS_POS_MIN)) begin
      clamped = PTCS_POS_MIN;
    end else if (!i_inc_system && (i_sp_pos > PTCS_POS_MAX)) begin
      clamped = PTCS_POS_MAX;
    end
  end

  assign o_sp_ready = (hstate_reg == PTCS_H_IDLE);

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hstate_reg <= PTCS_H_IDLE;
      pos_reg <= PTCS_POS_RST;
      speed_reg <= PTCS_WORD_RST;
      link.rw_we <= 1'b0;
      link.rw_addr <= 4'h0;
      link.rw_data <= PTCS_WORD_RST;
    end else begin
      link.rw_we <= 1'b0;
      case (hstate_reg)
        PTCS_H_IDLE: begin
          if (i_sp_valid) begin
            pos_reg <= clamped;
            speed_reg <= i_sp_speed;
            hstate_reg <= PTCS_H_LO;
          end
        end
        PTCS_H_LO: begin
          link.rw_we <= 1'b1;
          link.rw_addr <= PTCS_OFS_POS_LO;
          link.rw_data <= pos_reg[15:0];
          hstate_reg <= PTCS_H_HI;
        end
        PTCS_H_HI: begin
          link.rw_we <= 1'b1;
          link.rw_addr <= PTCS_OFS_POS_HI;
          link.rw_data <= pos_reg[31:16];
          hstate_reg <= PTCS_H_SPD;
        end
        PTCS_H_SPD: begin
          link.rw_we <= 1'b1;
          link.rw_addr <= PTCS_OFS_SPEED;
          link.rw_data <= speed_reg;
          hstate_reg <= PTCS_H_IDLE;
        end
        default: hstate_reg <= PTCS_H_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // point table load with chain fields made legal
  // ----------------------------------------------------------------------
  always_comb begin
    fixed = i_pt_data;
    fixed.dwell = PTCS_WORD_RST;
    if (i_pt_last && (i_inc_system || !ptcs_is_end(i_pt_data.aux))) begin
      fixed.aux = PTCS_AUX_END;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      link.pt_we <= 1'b0;
      link.pt_addr <= 8'h00;
      link.pt_data <= '0;
    end else begin
      link.pt_we <= i_pt_we;
      link.pt_addr <= i_pt_addr;
      link.pt_data <= fixed;
    end
  end

  assign o_busy = link.busy;
  assign o_held = link.held;
endmodule : ptcs_host
`default_nettype wire

// File: ptcs_link_assertions.sv
// concurrent checks on the link and the sequencer command outputs
`timescale 1ns/1ps
`default_nettype none
module ptcs_checker
  import ptcs_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // link
  input wire logic fwd_start,
  input wire logic auto_manual_select,
  input wire logic temporary_stop_request,
  input wire logic setpoint_source_select,
  input wire logic abs_inc_select,
  input wire logic rw_we,
  input wire logic [3:0] rw_addr,
  input wire logic [15:0] rw_data,
  input wire logic [3:0] command_system_param,
  input wire logic [3:0] setpoint_source_param,
  input wire logic [1:0] station_count,
  input wire logic busy,
  input wire logic held,
  // sequencer side
  input wire logic i_homing_active,
  input wire logic i_jog_active,
  input wire logic i_seg_done,
  input wire logic o_cmd_valid,
  input wire logic signed [31:0] o_cmd_target,
  input wire logic [15:0] o_cmd_speed,
  input wire logic [15:0] o_cmd_acc,
  input wire logic [15:0] o_cmd_dec,
  input wire logic o_cmd_last,
  input wire logic o_hold,
  input wire logic signed [31:0] o_remaining
);
  // ----
  // helper state
  // ----
  logic in_run;
  logic [15:0] pos_lo;
  logic [15:0] pos_hi;
  logic [15:0] spd;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      in_run <= 1'b0;
    end else begin
      in_run <= o_cmd_valid | (in_run & busy & !held & !i_seg_done);
    end
  end
  // shadow of the remote words as the master wrote them
  always_ff @(posedge i_ref_clk) begin
    if (rw_we && rw_addr == PTCS_OFS_POS_LO) pos_lo <= rw_data;
    if (rw_we && rw_addr == PTCS_OFS_POS_HI) pos_hi <= rw_data;
    if (rw_we && rw_addr == PTCS_OFS_SPEED) spd <= rw_data;
  end
  // ----
  // properties
  // ----
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  sequence s_stop_ok;
    $rose(temporary_stop_request) && auto_manual_select && !i_homing_active && !i_jog_active;
  endsequence
  sequence s_reg_start;
    $rose(fwd_start) && auto_manual_select && !busy && setpoint_source_select && !abs_inc_select
      && setpoint_source_param == PTCS_SRC_PARAM_REG && station_count == PTCS_STATIONS_REG
      && command_system_param == PTCS_CMD_SYS_ABS;
  endsequence
  a_start_to_cmd: assert property ($rose(fwd_start) && auto_manual_select && !busy
    |-> ##[1:2] o_cmd_valid) else $error("start gave no command");
  a_start_held_ignored: assert property (held && $rose(fwd_start)
    && !$rose(temporary_stop_request) |=> !o_cmd_valid) else $error("start acted in hold");
  a_stop_enters_hold: assert property ((in_run && !held) ##0 s_stop_ok
    |=> held && o_hold && $stable(o_cmd_dec)) else $error("stop did not hold");
  a_resume_same_target: assert property (held ##0 s_stop_ok
    |=> !held && !o_hold && o_cmd_valid && $stable(o_cmd_target)) else $error("bad resume");
  a_jog_no_stop: assert property ((i_homing_active || i_jog_active) && !held
    && $rose(temporary_stop_request) |=> !held) else $error("stop taken in manual motion");
  a_manual_clears_rest: assert property (held && !auto_manual_select
    |=> !busy && o_remaining == 32'sh0000_0000) else $error("remaining not cleared");
  a_accdec_kept: assert property (o_cmd_valid && $past(busy) && $past(busy, 2)
    |-> $stable(o_cmd_acc) && $stable(o_cmd_dec)) else $error("chain changed acc or dec");
  a_reg_setpoint_used: assert property (s_reg_start |=> o_cmd_valid && o_cmd_last
    && o_cmd_speed == spd && o_cmd_target == {pos_hi, pos_lo}) else $error("bad reg move");
endmodule : ptcs_checker
`default_nettype wire

// File: ptcs_link_if.sv
// remote bits, remote words and table loading between master and sequencer
`timescale 1ns/1ps
`default_nettype none
interface ptcs_link_if;
  import ptcs_pkg::*;
  // remote bits
  logic fwd_start;
  logic rev_start;
  logic auto_manual_select;
  logic temporary_stop_request;
  logic setpoint_source_select;
  logic abs_inc_select;
  logic [7:0] pt_select;
  // remote register words
  logic rw_we;
  logic [3:0] rw_addr;
  logic [15:0] rw_data;
  // configuration
  logic [3:0] command_system_param;
  logic [3:0] setpoint_source_param;
  logic [1:0] station_count;
  // point table load
  logic pt_we;
  logic [7:0] pt_addr;
  ptcs_entry_t pt_data;
  // status back to master
  logic busy;
  logic held;

  modport dev (
    input fwd_start, rev_start, auto_manual_select, temporary_stop_request,
    input setpoint_source_select, abs_inc_select, pt_select,
    input rw_we, rw_addr, rw_data,
    input command_system_param, setpoint_source_param, station_count,
    input pt_we, pt_addr, pt_data,
    output busy, held
  );
  modport host (
    output fwd_start, rev_start, auto_manual_select, temporary_stop_request,
    output setpoint_source_select, abs_inc_select, pt_select,
    output rw_we, rw_addr, rw_data,
    output command_system_param, setpoint_source_param, station_count,
    output pt_we, pt_addr, pt_data,
    input busy, held
  );
endinterface : ptcs_link_if
`default_nettype wire

// File: ptcs_pkg.sv
// shared constants and types of the point table chain sequencer
package ptcs_pkg;
  // remote register word offsets
  localparam logic [3:0] PTCS_OFS_POS_LO = 4'h4;
  localparam logic [3:0] PTCS_OFS_POS_HI = 4'h5;
  localparam logic [3:0] PTCS_OFS_SPEED = 4'h6;
  // parameter codes
  localparam logic [3:0] PTCS_CMD_SYS_ABS = 4'h0;
  localparam logic [3:0] PTCS_CMD_SYS_INC = 4'h1;
  localparam logic [3:0] PTCS_SRC_PARAM_REG = 4'h2;
  localparam logic [3:0] PTCS_SRC_PARAM_TABLE = 4'h0;
  localparam logic [1:0] PTCS_STATIONS_REG = 2'h2;
  // auxiliary function codes
  localparam logic [1:0] PTCS_AUX_END = 2'h0;
  localparam logic [1:0] PTCS_AUX_NEXT_ABS = 2'h1;
  localparam logic [1:0] PTCS_AUX_END_ALT = 2'h2;
  localparam logic [1:0] PTCS_AUX_NEXT_INC = 2'h3;
  // register position limits in the absolute system
  localparam logic signed [31:0] PTCS_POS_MIN = 32'shFF67_6981;
  localparam logic signed [31:0] PTCS_POS_MAX = 32'sh000F_423F;
  // reset values and point table depth
  localparam logic [15:0] PTCS_WORD_RST = 16'h0000;
  localparam logic [31:0] PTCS_POS_RST = 32'h0000_0000;
  localparam int PTCS_PT_DEPTH = 256;

  typedef struct packed {
    logic signed [31:0] pos;
    logic [15:0] speed;
    logic [15:0] acc;
    logic [15:0] dec;
    logic [15:0] dwell;
    logic [1:0] aux;
  } ptcs_entry_t;

  // a code of 0 or 2 closes a chain in the absolute system; the incremental system closes only on 0
  function automatic logic ptcs_is_end(input logic [1:0] aux);
    ptcs_is_end = (aux == PTCS_AUX_END) || (aux == PTCS_AUX_END_ALT);
  endfunction : ptcs_is_end
endpackage : ptcs_pkg

// File: ptcs_point_table.sv
// point table storage with one write port and one combinational read port
`timescale 1ns/1ps
`default_nettype none
module ptcs_point_table
  import ptcs_pkg::*;
(
  // clock
  input wire logic i_ref_clk,
  // write port
  input wire logic i_we,
  input wire logic [7:0] i_waddr,
  input wire ptcs_entry_t i_wdata,
  // read port
  input wire logic [7:0] i_raddr,
  output ptcs_entry_t o_rdata
);
  ptcs_entry_t mem [PTCS_PT_DEPTH];

  always_ff @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  assign o_rdata = mem[i_raddr];
endmodule : ptcs_point_table
`default_nettype wire

// File: ptcs_tb.sv
// self-checking bench: host and sequencer joined by the link interface
`timescale 1ns/1ps
`default_nettype none
module ptcs_tb;
  import ptcs_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic fs, rs, au, sr, rgs, ai, inc, spv, ptwe, ptl, hom, jog, sd, spr, busy, held, cv, cl, ho;
  logic [7:0] psel;
  logic [7:0] pta;
  ptcs_entry_t ptd;
  logic signed [31:0] spp;
  logic signed [31:0] cp;
  logic signed [31:0] ct;
  logic signed [31:0] rem;
  logic [15:0] sps, csp, ca, cd;
  int error_cnt = 0;
  int samples_checked = 0;
  always #10 i_ref_clk = ~i_ref_clk;
  ptcs_link_if lk ();
  ptcs_host ptcs_host_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(lk), .i_fwd_start(fs),
    .i_rev_start(rs), .i_auto(au), .i_stop_request(sr), .i_reg_setpoints(rgs), .i_abs_inc(ai),
    .i_pt_select(psel), .i_inc_system(inc), .i_sp_valid(spv), .i_sp_pos(spp), .i_sp_speed(sps),
    .o_sp_ready(spr), .i_pt_we(ptwe), .i_pt_addr(pta), .i_pt_data(ptd), .i_pt_last(ptl),
    .o_busy(busy), .o_held(held));
  ptcs_device ptcs_device_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(lk),
    .i_homing_active(hom), .i_jog_active(jog), .i_seg_done(sd), .i_cur_pos(cp),
    .o_cmd_valid(cv), .o_cmd_target(ct), .o_cmd_speed(csp), .o_cmd_acc(ca), .o_cmd_dec(cd),
    .o_cmd_last(cl), .o_hold(ho), .o_remaining(rem));
  ptcs_checker ptcs_checker_i (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .fwd_start(lk.fwd_start), .auto_manual_select(lk.auto_manual_select),
    .temporary_stop_request(lk.temporary_stop_request),
    .setpoint_source_select(lk.setpoint_source_select), .abs_inc_select(lk.abs_inc_select),
    .rw_we(lk.rw_we), .rw_addr(lk.rw_addr), .rw_data(lk.rw_data),
    .command_system_param(lk.command_system_param),
    .setpoint_source_param(lk.setpoint_source_param), .station_count(lk.station_count),
    .busy(lk.busy), .held(lk.held), .i_homing_active(hom), .i_jog_active(jog), .i_seg_done(sd),
    .o_cmd_valid(cv), .o_cmd_target(ct), .o_cmd_speed(csp), .o_cmd_acc(ca), .o_cmd_dec(cd),
    .o_cmd_last(cl), .o_hold(ho), .o_remaining(rem));
  // ----
  // tasks
  // ----
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop
  // entry with acc c, dec c+50, zero dwell; aux 0 closes the chain
  task automatic ld(input logic [7:0] a, input logic [31:0] p, input logic [15:0] s,
                    input logic [15:0] c, input logic [1:0] x);
    @(negedge i_ref_clk);
    ptwe = 1'b1;
    pta = a;
    ptd = {p, s, c, c + 16'h0032, 16'h0000, x};
    ptl = (x == 2'h0);
    @(negedge i_ref_clk);
    ptwe = 1'b0;
  endtask : ld
  task automatic wcmd(input logic [31:0] e);
    for (int i = 0; i < 10; i++) begin
      @(posedge i_ref_clk);
      #1;
      if (cv === 1'b1) break;
    end
    chk({7'h00, cv, ct}, {8'h01, e});
  endtask : wcmd
  task automatic go(input logic r, input logic [31:0] e);
    @(negedge i_ref_clk);
    fs = !r;
    rs = r;
    wcmd(e);
    @(negedge i_ref_clk);
    fs = 1'b0;
    rs = 1'b0;
  endtask : go
  task automatic seg();
    @(negedge i_ref_clk);
    sd = 1'b1;
    @(negedge i_ref_clk);
    sd = 1'b0;
  endtask : seg
  task automatic rest(input logic [31:0] b, input logic [31:0] c);
    seg();
    wcmd(b);
    seg();
    wcmd(c);
    chk(cl, 1'b1);
    seg();
    repeat (3) @(negedge i_ref_clk);
    chk(busy, 1'b0);
  endtask : rest
  task automatic sp(input logic [31:0] p);
    @(negedge i_ref_clk);
    spp = p;
    spv = 1'b1;
    @(negedge i_ref_clk);
    spv = 1'b0;
    repeat (6) @(negedge i_ref_clk);
  endtask : sp
  // ----
  // tests
  // ----
  initial begin
    {fs, rs, au, sr, rgs, ai, inc, spv, ptwe, ptl, hom, jog, sd} = '0;
    psel = 8'h01;
    pta = 8'h00;
    ptd = '0;
    spp = 32'h0000_0000;
    sps = 16'h0309;
    cp = 32'h0000_1000;
    repeat (12) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    i_rst_n = 1'b1;
    chk({held, busy, spr}, 3'b001);
    ld(8'h01, 32'h0000_01F4, 16'h0BB8, 16'h0064, 2'h1);
    ld(8'h02, 32'h0000_012C, 16'h07D0, 16'h0000, 2'h3);
    ld(8'h03, 32'h0000_03E8, 16'h03E8, 16'h0000, 2'h0);
    au = 1'b1;
    go(1'b0, 32'h0000_01F4);
    // a new selection mid-chain must not redirect the running chain
    psel = 8'h03;
    rest(32'h0000_012C, 32'h0000_0514);
    chk({ca, cd, csp}, {16'h0064, 16'h0096, 16'h03E8});
    psel = 8'h01;
    go(1'b0, 32'h0000_01F4);
    cp = 32'h0000_0064;
    @(negedge i_ref_clk);
    sr = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    chk({held, ho, cd, rem}, {2'b11, 16'h0096, 32'h0000_0190});
    fs = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    chk({held, busy, cv}, 3'b110);
    fs = 1'b0;
    sr = 1'b0;
    @(negedge i_ref_clk);
    sr = 1'b1;
    wcmd(32'h0000_01F4);
    chk(ho, 1'b0);
    @(negedge i_ref_clk);
    sr = 1'b0;
    @(negedge i_ref_clk);
    sr = 1'b1;
    repeat (3) @(negedge i_ref_clk);
    au = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    chk({busy, rem}, 33'h0);
    au = 1'b1;
    sr = 1'b0;
    jog = 1'b1;
    go(1'b0, 32'h0000_01F4);
    @(negedge i_ref_clk);
    sr = 1'b1;
    repeat (4) @(negedge i_ref_clk);
    chk(held, 1'b0);
    sr = 1'b0;
    jog = 1'b0;
    rest(32'h0000_012C, 32'h0000_0514);
    inc = 1'b1;
    for (int r = 0; r < 2; r++) begin
      go(r[0], r ? cp - 32'h0000_01F4 : cp + 32'h0000_01F4);
      rest(r ? cp - 32'h0000_0320 : cp + 32'h0000_0320,
           r ? cp - 32'h0000_0708 : cp + 32'h0000_0708);
    end
    inc = 1'b0;
    rgs = 1'b1;
    sp(32'hFFFF_CFC7);
    go(1'b0, 32'hFFFF_CFC7);
    chk({cl, csp}, {1'b1, 16'h0309});
    seg();
    ai = 1'b1;
    cp = 32'h0000_03E8;
    repeat (3) @(negedge i_ref_clk);
    go(1'b0, 32'hFFFF_D3AF);
    seg();
    ai = 1'b0;
    sp(32'hFF00_0000);
    go(1'b0, 32'hFF67_6981);
    seg();
    repeat (3) @(negedge i_ref_clk);
    report_and_stop();
  end
  initial begin
    #400000;
    error_cnt++;
    report_and_stop();
  end
endmodule : ptcs_tb
`default_nettype wire
